// file: hdl/cclt_pkg.sv
// Package of register map, field layout and timing constants for the control-line trigger
package cclt_pkg;
    // ********************************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************************
    localparam logic [5:0] REG_AUX_C_IDX    = 6'h05;
    localparam logic [5:0] REG_LINE_IDX     = 6'h07;
    localparam logic [5:0] REG_AUX_B_IDX    = 6'h10;
    localparam logic [5:0] REG_EXPOSURE_IDX = 6'h20;
    localparam logic [5:0] REG_SER_CFG_IDX  = 6'h21;
    localparam logic [5:0] REG_SER_GAP_IDX  = 6'h22;
    localparam logic [5:0] REG_STATUS_IDX   = 6'h23;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int AUXC_NARROW_BIT  = 4;
    localparam int AUXB_PHOTO_BIT   = 0;
    localparam int AUXB_LEGACY_BIT  = 1;
    localparam int AUXB_SPARE_BIT   = 4;
    localparam int SCFG_RS232_BIT   = 0;
    localparam int SCFG_EXPO_BIT    = 1;
    localparam int SCFG_MODE5_BIT   = 2;
    localparam int ST_PULSE_BIT     = 0;
    localparam int ST_EXT_BIT       = 1;
    localparam int ST_FVAL_BIT      = 2;
    localparam int ST_GAP_BIT       = 3;
    localparam int ST_JUMPER_BIT    = 4;

    // ********************************************************************
    // Reset values and nibble codes
    // ********************************************************************
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [15:0] HALF_RESET   = 16'h0000;
    localparam logic [15:0] ONE_MS       = 16'h0001;
    localparam logic [3:0]  NIB_NONE     = 4'h0;
    localparam logic [3:0]  NIB_OPTO_L1  = 4'hA;
    localparam logic [3:0]  NIB_OPTO_L2  = 4'hB;
    localparam logic [3:0]  NIB_FVAL_L4  = 4'hC;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_TIME_NS    = 1000000;
    localparam int MS_CYCLES_DEF = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cclt_pkg

// file: hdl/cclt_pulse_if.sv
// Interface between the controller and a millisecond pulse generator
`timescale 1ns/1ps
interface cclt_pulse_if #(parameter int WIDTH_W = 16);
    logic               start;
    logic [WIDTH_W-1:0] width_ms;
    logic               busy;
    logic               done;

    // Generator end and controlling end
    modport gen (input start, input width_ms, output busy, output done);
    modport ctl (output start, output width_ms, input busy, input done);
endinterface : cclt_pulse_if

// file: hdl/cclt_pulse_gen.sv
// Pulse generator counting whole milliseconds of clock cycles
`timescale 1ns/1ps
module cclt_pulse_gen
    import cclt_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int WIDTH_W   = 16
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Pulse request and status
    cclt_pulse_if.gen   pi
);
    typedef enum logic {PG_IDLE, PG_ACTIVE} cclt_pg_state_t;

    localparam int CYC_W = $clog2(MS_CYCLES + 1);
    localparam logic [CYC_W-1:0]   CYC_LAST = CYC_W'(MS_CYCLES - 1);
    localparam logic [WIDTH_W-1:0] W_ONE    = WIDTH_W'(1);

    if (MS_CYCLES < 2) begin : g_chk
        $error("MS_CYCLES must be at least 2");
    end

    cclt_pg_state_t     state_r;
    logic [CYC_W-1:0]   cyc_r;
    logic [WIDTH_W-1:0] ms_left_r;
    logic               term;

    assign term    = (cyc_r == CYC_LAST);
    assign pi.busy = (state_r == PG_ACTIVE);
    assign pi.done = (state_r == PG_ACTIVE) && term && (ms_left_r == W_ONE);

    // ********************************************************************
    // Pulse sequencing
    // ********************************************************************
    // Start only from idle; requests during a pulse are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= PG_IDLE;
            cyc_r     <= '0;
            ms_left_r <= '0;
        end else begin
            case (state_r)
                PG_IDLE: begin
                    cyc_r <= '0;
                    if (pi.start) begin
                        state_r   <= PG_ACTIVE;
                        ms_left_r <= (pi.width_ms == '0) ? W_ONE : pi.width_ms;
                    end
                end
                PG_ACTIVE: begin
                    // Cycle counter sets the millisecond length
                    if (term) begin
                        cyc_r     <= '0;
                        ms_left_r <= ms_left_r - W_ONE;
                        if (ms_left_r == W_ONE) begin
                            state_r <= PG_IDLE;
                        end
                    end else begin
                        cyc_r <= cyc_r + CYC_W'(1);
                    end
                end
                default: state_r <= PG_IDLE;
            endcase
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    logic [31:0] len_r;
    logic [31:0] want_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            len_r  <= '0;
            want_r <= '0;
        end else if (!pi.busy && pi.start) begin
            len_r  <= 32'h1;
            want_r <= 32'((pi.width_ms == '0) ? W_ONE : pi.width_ms) * 32'(MS_CYCLES);
        end else if (pi.busy) begin
            len_r <= len_r + 32'h1;
        end
    end

    pulse_len_a: assert property (@(posedge clk) disable iff (rst)
        pi.done |-> len_r == want_r)
        else $error("pulse length differs from programmed width");
    busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (pi.busy && pi.start && !term) |=> ms_left_r == $past(ms_left_r))
        else $error("pulse restarted while active");
    pulse_seen_c: cover property (@(posedge clk) disable iff (rst) pi.done);
endmodule : cclt_pulse_gen

// file: hdl/cclt_ctrl_line_trigger.sv
// Camera control-line driver with trigger pulses, alternate sources and utility bits
// Notes on behaviour
// - Low nibble of line control sets each control line's idle level.
// - High nibble picks pulsed lines; zero means no pulses at all.
// - Nonzero pulse nibble gives a one-millisecond pulse per acquisition on chosen lines.
// - In exposure-timed mode the pulse lasts the programmed exposure instead.
// - Code A drives line 1 from the optocoupled external trigger.
// - Code B drives line 2 from the optocoupler, lines 1, 3, 4 low.
// - Code C drives line 4 with frame-valid for forwarded frames only.
// - Aux C bit 4 selects narrow link format; clear means wide; resets clear.
// - Aux B bit 0 lets external or fixed-period trigger fire and arm.
// - Photo-trigger mode suppresses the end-of-transfer interrupt.
// - Aux B bit 4 turns the serial-out pair into a fifth mode output.
// - Aux B holds a legacy camera compatibility bit.
// - Serial channel differential by default; RS232 only if selected and jumper agrees.
// - Optional millisecond gap inserted between serial characters.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module cclt_ctrl_line_trigger
    import cclt_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        SRST,
    // Avalon-MM slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Acquisition and trigger sources
    input  wire logic        ACQ_REQ,
    input  wire logic        FIXED_TRIG,
    input  wire logic        EXT_TRIG_PIN,
    input  wire logic        FRAME_VALID_PIN,
    input  wire logic        FRAME_TO_HOST,
    input  wire logic        DMA_DONE,
    // Serial channel
    input  wire logic        SER_CTRL_OUT_IN,
    input  wire logic        SER_CHAR_DONE,
    input  wire logic        DIFFERENTIAL_JUMPER_SETTING_JUMPER_PIN,
    // Camera side and board outputs
    output logic      [3:0]  CAM_CTRL_LINE,
    output logic             SER_PAIR_OUT,
    output logic             SER_TX_HOLD,
    output logic             SER_RS232_SEL,
    output logic             LINK_NARROW_FMT,
    output logic             LEGACY_CAM,
    output logic             ARM_ACQ,
    output logic             DMA_IRQ
);
    localparam int NPIN = 3;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    // True for nibbles that request plain trigger pulses
    function automatic logic is_pulse_code(input logic [3:0] nib);
        is_pulse_code = (nib != NIB_NONE) && (nib != NIB_OPTO_L1)
                     && (nib != NIB_OPTO_L2) && (nib != NIB_FVAL_L4);
    endfunction : is_pulse_code

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [NPIN-1:0] pin_s3_r;
    logic [NPIN-1:0] pin_r;
    assign pin_in = {DIFFERENTIAL_JUMPER_SETTING_JUMPER_PIN, FRAME_VALID_PIN, EXT_TRIG_PIN};

    // Three stages; level accepted once stages two and three agree
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        always_ff @(posedge MCLK) begin
            if (SRST) begin
                pin_s1_r[g] <= 1'b0;
                pin_s2_r[g] <= 1'b0;
                pin_s3_r[g] <= 1'b0;
                pin_r[g]    <= 1'b0;
            end else begin
                pin_s1_r[g] <= pin_in[g];
                pin_s2_r[g] <= pin_s1_r[g];
                pin_s3_r[g] <= pin_s2_r[g];
                if (pin_s2_r[g] == pin_s3_r[g]) begin
                    pin_r[g] <= pin_s3_r[g];
                end
            end
        end
    end

    logic ext_trig;
    logic frame_valid;
    logic jumper_differential_jumper_setting;
    logic ext_prev_r;
    logic ext_rise;
    assign ext_trig    = pin_r[0];
    assign frame_valid = pin_r[1];
    assign jumper_differential_jumper_setting = pin_r[2];
    assign ext_rise    = ext_trig && !ext_prev_r;

    // Edge detector on the accepted trigger level
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= ext_trig;
        end
    end

    // ********************************************************************
    // Register file and bus slave
    // ********************************************************************
    logic [7:0]  aux_control_c_r;
    logic [7:0]  line_control_r;
    logic [7:0]  aux_control_b_r;
    logic [15:0] exposure_ms_r;
    logic [7:0]  serial_cfg_r;
    logic [15:0] serial_gap_ms_r;
    logic        ack_r;
    logic        req;
    logic        wr_en;
    logic [5:0]  idx;
    logic        aligned;
    logic [31:0] rd_nxt;
    logic [7:0]  status;

    assign req             = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !ack_r;
    assign wr_en           = AVS_WRITE && ack_r;
    assign idx             = AVS_ADDRESS[7:2];
    assign aligned         = (AVS_ADDRESS[1:0] == 2'b00);

    // One wait cycle per access, then the answer
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // Register writes, lane by lane
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            aux_control_c_r <= BYTE_RESET;
            line_control_r  <= BYTE_RESET;
            aux_control_b_r <= BYTE_RESET;
            exposure_ms_r   <= ONE_MS;
            serial_cfg_r    <= BYTE_RESET;
            serial_gap_ms_r <= HALF_RESET;
        end else if (wr_en && aligned) begin
            if (idx == REG_AUX_C_IDX) begin
                if (AVS_BYTEENABLE[0]) aux_control_c_r <= AVS_WRITEDATA[7:0];
            end else if (idx == REG_LINE_IDX) begin
                if (AVS_BYTEENABLE[0]) line_control_r <= AVS_WRITEDATA[7:0];
            end else if (idx == REG_AUX_B_IDX) begin
                if (AVS_BYTEENABLE[0]) aux_control_b_r <= AVS_WRITEDATA[7:0];
            end else if (idx == REG_EXPOSURE_IDX) begin
                if (AVS_BYTEENABLE[0]) exposure_ms_r[7:0]  <= AVS_WRITEDATA[7:0];
                if (AVS_BYTEENABLE[1]) exposure_ms_r[15:8] <= AVS_WRITEDATA[15:8];
            end else if (idx == REG_SER_CFG_IDX) begin
                if (AVS_BYTEENABLE[0]) serial_cfg_r <= AVS_WRITEDATA[7:0];
            end else if (idx == REG_SER_GAP_IDX) begin
                if (AVS_BYTEENABLE[0]) serial_gap_ms_r[7:0]  <= AVS_WRITEDATA[7:0];
                if (AVS_BYTEENABLE[1]) serial_gap_ms_r[15:8] <= AVS_WRITEDATA[15:8];
            end
        end
    end

    // Read multiplexer; unmapped reads return zero
    always_comb begin
        rd_nxt = '0;
        if (!aligned) begin
            rd_nxt = '0;
        end else if (idx == REG_AUX_C_IDX) begin
            rd_nxt[7:0] = aux_control_c_r;
        end else if (idx == REG_LINE_IDX) begin
            rd_nxt[7:0] = line_control_r;
        end else if (idx == REG_AUX_B_IDX) begin
            rd_nxt[7:0] = aux_control_b_r;
        end else if (idx == REG_EXPOSURE_IDX) begin
            rd_nxt[15:0] = exposure_ms_r;
        end else if (idx == REG_SER_CFG_IDX) begin
            rd_nxt[7:0] = serial_cfg_r;
        end else if (idx == REG_SER_GAP_IDX) begin
            rd_nxt[15:0] = serial_gap_ms_r;
        end else if (idx == REG_STATUS_IDX) begin
            rd_nxt[7:0] = status;
        end
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            AVS_READDATA <= '0;
        end else if (AVS_READ && !ack_r) begin
            AVS_READDATA <= rd_nxt;
        end
    end

    // ********************************************************************
    // Mode decode
    // ********************************************************************
    logic [3:0] idle_lvl;
    logic [3:0] nib;
    logic       photo_mode;
    logic       expo_mode;
    logic       fire;
    assign idle_lvl   = line_control_r[3:0];
    assign nib        = line_control_r[7:4];
    assign photo_mode = aux_control_b_r[AUXB_PHOTO_BIT];
    assign expo_mode  = serial_cfg_r[SCFG_EXPO_BIT];
    // Acquisition from software or, in photo mode, from a trigger source
    assign fire       = ACQ_REQ || (photo_mode && (ext_rise || FIXED_TRIG));

    // ********************************************************************
    // Trigger pulse and serial gap generators
    // ********************************************************************
    cclt_pulse_if #(.WIDTH_W(16)) trig_pi ();
    cclt_pulse_if #(.WIDTH_W(16)) gap_pi ();

    assign trig_pi.start    = fire && is_pulse_code(nib);
    assign trig_pi.width_ms = expo_mode ? exposure_ms_r : ONE_MS;
    assign gap_pi.start     = SER_CHAR_DONE && (serial_gap_ms_r != HALF_RESET);
    assign gap_pi.width_ms  = serial_gap_ms_r;

    cclt_pulse_gen #(.MS_CYCLES(MS_CYCLES), .WIDTH_W(16)) u_trig (
        .clk (MCLK),
        .rst (SRST),
        .pi  (trig_pi)
    );

    cclt_pulse_gen #(.MS_CYCLES(MS_CYCLES), .WIDTH_W(16)) u_gap (
        .clk (MCLK),
        .rst (SRST),
        .pi  (gap_pi)
    );

    assign SER_TX_HOLD = gap_pi.busy;

    // ********************************************************************
    // Control line drive
    // ********************************************************************
    logic [3:0] line_nxt;
    always_comb begin
        line_nxt = idle_lvl;
        if (nib == NIB_OPTO_L1) begin
            line_nxt[0] = ext_trig;
        end else if (nib == NIB_OPTO_L2) begin
            line_nxt    = 4'h0;
            line_nxt[1] = ext_trig;
        end else if (nib == NIB_FVAL_L4) begin
            line_nxt[3] = frame_valid && FRAME_TO_HOST;
        end else if (is_pulse_code(nib) && trig_pi.busy) begin
            line_nxt = idle_lvl ^ nib;
        end
    end

    // Registered outputs toward camera and host
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            CAM_CTRL_LINE <= 4'h0;
            ARM_ACQ       <= 1'b0;
            DMA_IRQ       <= 1'b0;
            SER_PAIR_OUT  <= 1'b0;
        end else begin
            CAM_CTRL_LINE <= line_nxt;
            ARM_ACQ       <= photo_mode && (ext_rise || FIXED_TRIG);
            DMA_IRQ       <= DMA_DONE && !photo_mode;
            SER_PAIR_OUT  <= aux_control_b_r[AUXB_SPARE_BIT] ?
                             serial_cfg_r[SCFG_MODE5_BIT] : SER_CTRL_OUT_IN;
        end
    end

    // Static configuration outputs
    assign LINK_NARROW_FMT = aux_control_c_r[AUXC_NARROW_BIT];
    assign LEGACY_CAM      = aux_control_b_r[AUXB_LEGACY_BIT];
    assign SER_RS232_SEL   = serial_cfg_r[SCFG_RS232_BIT] && !jumper_differential_jumper_setting;

    // Status readback
    always_comb begin
        status                = '0;
        status[ST_PULSE_BIT]  = trig_pi.busy;
        status[ST_EXT_BIT]    = ext_trig;
        status[ST_FVAL_BIT]   = frame_valid;
        status[ST_GAP_BIT]    = gap_pi.busy;
        status[ST_JUMPER_BIT] = jumper_differential_jumper_setting;
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    idle_level_a: assert property (@(posedge MCLK) disable iff (SRST)
        (nib == NIB_NONE) |=> CAM_CTRL_LINE == $past(idle_lvl))
        else $error("idle level not driven");
    no_pulse_a: assert property (@(posedge MCLK) disable iff (SRST)
        (nib == NIB_NONE) |-> !trig_pi.start)
        else $error("pulse started with zero nibble");
    fixed_width_a: assert property (@(posedge MCLK) disable iff (SRST)
        (trig_pi.start && !expo_mode) |-> trig_pi.width_ms == ONE_MS)
        else $error("fixed pulse not one millisecond");
    expo_width_a: assert property (@(posedge MCLK) disable iff (SRST)
        (trig_pi.start && expo_mode) |-> trig_pi.width_ms == exposure_ms_r)
        else $error("exposure width not applied");
    opto_line1_a: assert property (@(posedge MCLK) disable iff (SRST)
        (nib == NIB_OPTO_L1) |=> CAM_CTRL_LINE[0] == $past(ext_trig))
        else $error("line 1 not following optocoupler");
    opto_line2_a: assert property (@(posedge MCLK) disable iff (SRST)
        (nib == NIB_OPTO_L2) |=> CAM_CTRL_LINE == {2'b00, $past(ext_trig), 1'b0})
        else $error("line 2 mode wrong");
    fval_line4_a: assert property (@(posedge MCLK) disable iff (SRST)
        (nib == NIB_FVAL_L4 && !FRAME_TO_HOST) |=> !CAM_CTRL_LINE[3])
        else $error("frame-valid shown for unforwarded frame");
    link_fmt_a: assert property (@(posedge MCLK) disable iff (SRST)
        (wr_en && aligned && idx == REG_AUX_C_IDX && AVS_BYTEENABLE[0])
        |=> LINK_NARROW_FMT == $past(AVS_WRITEDATA[AUXC_NARROW_BIT]))
        else $error("link format bit not updated");
    photo_arm_a: assert property (@(posedge MCLK) disable iff (SRST)
        (photo_mode && ext_rise) |=> ARM_ACQ)
        else $error("external trigger did not arm");
    irq_block_a: assert property (@(posedge MCLK) disable iff (SRST)
        (DMA_DONE && photo_mode) |=> !DMA_IRQ)
        else $error("interrupt raised in photo mode");
    rs232_sel_a: assert property (@(posedge MCLK) disable iff (SRST)
        jumper_differential_jumper_setting |-> !SER_RS232_SEL)
        else $error("RS232 chosen against jumper");
    gap_hold_a: assert property (@(posedge MCLK) disable iff (SRST)
        (gap_pi.start && !gap_pi.busy) |=> SER_TX_HOLD [*2])
        else $error("serial gap not held");
    bus_answer_a: assert property (@(posedge MCLK) disable iff (SRST)
        $rose(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");

    trig_pulse_c: cover property (@(posedge MCLK) disable iff (SRST) trig_pi.done);
    photo_fire_c: cover property (@(posedge MCLK) disable iff (SRST) ARM_ACQ);
    gap_done_c:   cover property (@(posedge MCLK) disable iff (SRST) gap_pi.done);
    opto_drive_c: cover property (@(posedge MCLK) disable iff (SRST)
        nib == NIB_OPTO_L2 && CAM_CTRL_LINE[1]);
endmodule : cclt_ctrl_line_trigger

// file: verification/cclt_cam_model.sv
// Camera model: frame-valid source and pulse timer on control line 1
`timescale 1ns/1ps
module cclt_cam_model (
    // Clock
    input  wire logic        clk,
    // Control lines and frame request
    input  wire logic [3:0]  cam_line,
    input  wire logic        frame_on,
    // Frame valid and last pulse width seen on line 1
    output logic             frame_valid,
    output logic      [15:0] pulse_len
);
    logic [15:0] cnt_r;
    // Frame valid follows the frame request
    assign frame_valid = frame_on;
    // Measure each high time on line 1
    always_ff @(posedge clk) begin
        cnt_r <= cam_line[0] ? cnt_r + 16'h0001 : 16'h0000;
        if (!cam_line[0] && cnt_r != 16'h0000) begin
            pulse_len <= cnt_r;
        end
    end
endmodule : cclt_cam_model

// file: verification/tb_cclt_ctrl_line_trigger.sv
// Testbench for the camera control-line trigger block
`timescale 1ns/1ps
module tb_cclt_ctrl_line_trigger;
    import cclt_pkg::*;
    localparam int MSC = 8;
    logic        mclk, srst, rd, wr, acq, fix, ext, ft, dma, jmp, fon, wq, fv, sco, scd;
    logic        pair, hold, rs, nar, leg, arm, irq;
    logic [7:0]  addr;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  be, cam;
    logic [15:0] plen;
    int          n_mismatch, checks_done, cyc, n_irq, n_arm;
    cclt_ctrl_line_trigger #(.MS_CYCLES(MSC)) u_cclt_ctrl_line_trigger (
        .MCLK(mclk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wq), .ACQ_REQ(acq), .FIXED_TRIG(fix), .EXT_TRIG_PIN(ext),
        .FRAME_VALID_PIN(fv), .FRAME_TO_HOST(ft), .DMA_DONE(dma), .SER_CTRL_OUT_IN(sco),
        .SER_CHAR_DONE(scd), .DIFFERENTIAL_JUMPER_SETTING_JUMPER_PIN(jmp), .CAM_CTRL_LINE(cam),
        .SER_PAIR_OUT(pair), .SER_TX_HOLD(hold), .SER_RS232_SEL(rs),
        .LINK_NARROW_FMT(nar), .LEGACY_CAM(leg), .ARM_ACQ(arm), .DMA_IRQ(irq));
    cclt_cam_model u_cclt_cam_model (
        .clk(mclk), .cam_line(cam), .frame_on(fon), .frame_valid(fv), .pulse_len(plen));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Pulse counters and timeout
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) n_irq <= n_irq + 1;
        if (arm === 1'b1) n_arm <= n_arm + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    // Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        rd <= ~w; wr <= w; addr <= a; wdat <= d; be <= 4'hF;
        do @(posedge mclk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge mclk);
    endtask : bus
    // One-cycle strobe on char done, acq, fixed trigger, dma done; one idle edge after
    task automatic stb(input logic [3:0] s);
        {scd, acq, fix, dma} <= s;
        @(posedge mclk);
        {scd, acq, fix, dma} <= 4'h0;
        @(posedge mclk);
    endtask : stb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        {rd, wr, acq, fix, dma, ext, ft, fon, sco, scd} = 10'h000;
        jmp = 1'b1; addr = 8'h00; wdat = 32'h0; be = 4'h0; srst = 1'b1;
        cyc = 0; n_irq = 0; n_arm = 0; n_mismatch = 0; checks_done = 0;
        wt(5);
        srst <= 1'b0;
        wt(1);
        bus(0, 8'h14, 32'h0); chk("aux_c", 32'h0, q);
        chk("narrow", 32'h0, nar);
        bus(1, 8'h1C, 32'h05); wt(3); chk("lines", 32'h5, cam);
        stb(3'h4); wt(4); chk("no pulse", 32'h5, cam);
        $display("test reset and levels done");
        bus(1, 8'h1C, 32'h10); stb(3'h4); wt(3); stb(3'h4); wt(20);
        chk("width", MSC, plen);
        bus(1, 8'h80, 32'h3); bus(1, 8'h84, 32'h2); stb(3'h4); wt(40);
        chk("expo width", 3 * MSC, plen);
        bus(1, 8'h84, 32'h0);
        $display("test pulses done");
        bus(1, 8'h1C, 32'hA0); ext <= 1'b1; wt(8); chk("code a", 32'h1, cam);
        ext <= 1'b0; wt(8); chk("code a off", 32'h0, cam);
        bus(1, 8'h1C, 32'hBF); ext <= 1'b1; wt(8); chk("code b", 32'h2, cam);
        ext <= 1'b0; wt(8); chk("code b off", 32'h0, cam);
        bus(1, 8'h1C, 32'hC0); fon <= 1'b1; ft <= 1'b1; wt(8);
        chk("code c", 32'h8, cam);
        ft <= 1'b0; wt(3); chk("code c drop", 32'h0, cam);
        fon <= 1'b0;
        $display("test alternate sources done");
        bus(1, 8'h14, 32'h10); chk("narrow", 32'h1, nar);
        bus(1, 8'h40, 32'h03); chk("legacy", 32'h1, leg);
        ext <= 1'b1; wt(6); ext <= 1'b0;
        stb(3'h2); stb(3'h1); wt(4);
        chk("arm", 32'h2, n_arm);
        chk("irq blocked", 32'h0, n_irq);
        bus(1, 8'h40, 32'h00); stb(3'h1); wt(4); chk("irq", 32'h1, n_irq);
        sco <= 1'b1; wt(2); chk("serial pass", 32'h1, pair);
        sco <= 1'b0;
        bus(1, 8'h40, 32'h10); bus(1, 8'h84, 32'h4); wt(3);
        chk("fifth bit", 32'h1, pair);
        chk("serial differential_jumper_setting", 32'h0, rs);
        bus(1, 8'h84, 32'h1); jmp <= 1'b0; wt(8); chk("rs232", 32'h1, rs);
        jmp <= 1'b1; wt(8); chk("jumper differential_jumper_setting", 32'h0, rs);
        // Two-millisecond gap after a character, seen on hold and in status
        bus(1, 8'h88, 32'h2); stb(4'h8); bus(0, 8'h8C, 32'h0);
        chk("status gap", 32'h18, q);
        chk("gap hold", 32'h1, hold);
        bus(0, 8'h3C, 32'h0); chk("unmapped", 32'h0, q);
        wt(16); chk("gap end", 32'h0, hold);
        // Reset in mid-run brings registers back to their defaults
        srst <= 1'b1; wt(2); srst <= 1'b0; wt(1);
        chk("narrow reset", 32'h0, nar);
        bus(0, 8'h80, 32'h0); chk("exposure reset", 32'h1, q);
        $display("test utility bits done");
        print_verdict();
    end
endmodule : tb_cclt_ctrl_line_trigger
